// file: verilog/scs_defines.svh
// Constants of the serial channel communication setting block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Register byte addresses
`define SCS_ADR_SETTING 20'hF_0118
`define SCS_ADR_MODE 20'hF_011C
`define SCS_ADR_CTRL 20'hF_0120

// Setting register reset value, writable bits and fixed-one bits
`define SCS_SET_RESET 16'h0087
`define SCS_SET_WMASK 16'hF7B3
`define SCS_SET_FIXED1 16'h0004

// Setting register field positions
`define SCS_TXE_BIT 15
`define SCS_RXE_BIT 14
`define SCS_DAP_BIT 13
`define SCS_CKP_BIT 12
`define SCS_EIS_BIT 10
`define SCS_PAR_HI 9
`define SCS_PAR_LO 8
`define SCS_ORD_BIT 7
`define SCS_STOP_HI 5
`define SCS_STOP_LO 4
`define SCS_LEN_HI 1
`define SCS_LEN_LO 0

// Control register bits: write start/stop, read running/illegal
`define SCS_CTRL_START 0
`define SCS_CTRL_STOP 1
`define SCS_CTRL_ILLEGAL 1

// Data lengths in bits
`define SCS_LEN_SEVEN 4'h7
`define SCS_LEN_EIGHT 4'h8
`define SCS_LEN_NINE 4'h9

`endif

// file: verilog/scs_pkg.sv
// Types shared by the serial channel communication setting block.
// Assumes scs_defines.svh holds every offset and field position.
package scs_pkg;
   // Channel operating mode, in mode-field code order
   typedef enum logic [1:0] {SCS_CLOCKED, SCS_ASYNC, SCS_TWO_WIRE, SCS_BAD_MODE} scs_mode_type;
   // Parity handling, in parity-field code order
   typedef enum logic [1:0] {SCS_PAR_NONE, SCS_PAR_ZERO, SCS_PAR_EVEN, SCS_PAR_ODD}
      scs_parity_type;
endpackage : scs_pkg

// file: verilog/scs_frame_decode.sv
// Decodes a latched setting word and mode field into framing controls.
// Assumes its inputs are stable while the channel runs; purely combinational.
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_frame_decode
   import scs_pkg::*;
#(
   parameter bit HAS_NINE_BIT = 1'b1
)
(
   // Latched configuration
   input logic [15:0] setting,
   input logic [1:0] mode_field,
   // Decoded framing
   output scs_mode_type mode,
   output logic tx_en,
   output logic rx_en,
   output scs_parity_type parity,
   output logic msb_first,
   output logic [1:0] stop_count,
   output logic [3:0] data_bits,
   output logic err_sel,
   output logic illegal
);

   ////////////////////////////////////////////////////////////////////////
   // Field decode
   always_comb
   begin
      mode = scs_mode_type'(mode_field);
      tx_en = setting[`SCS_TXE_BIT];
      rx_en = setting[`SCS_RXE_BIT];
      parity = scs_parity_type'(setting[`SCS_PAR_HI:`SCS_PAR_LO]);
      msb_first = ~setting[`SCS_ORD_BIT];
      err_sel = setting[`SCS_EIS_BIT];
      illegal = (mode == SCS_BAD_MODE);
      // Stop bits; the prohibited code falls back to one stop bit
      unique case (setting[`SCS_STOP_HI:`SCS_STOP_LO])
         2'b00: stop_count = 2'd0;
         2'b01: stop_count = 2'd1;
         2'b10: stop_count = 2'd2;
         2'b11:
         begin
            stop_count = 2'd1;
            illegal = 1'b1;
         end
      endcase
      // Data length; prohibited codes fall back to eight bits
      unique case (setting[`SCS_LEN_HI:`SCS_LEN_LO])
         2'b01:
         begin
            if (HAS_NINE_BIT && mode == SCS_ASYNC)
            begin
               data_bits = `SCS_LEN_NINE;
            end
            else
            begin
               data_bits = `SCS_LEN_EIGHT;
               illegal = 1'b1;
            end
         end
         2'b10: data_bits = `SCS_LEN_SEVEN;
         2'b11: data_bits = `SCS_LEN_EIGHT;
         2'b00:
         begin
            data_bits = `SCS_LEN_EIGHT;
            illegal = 1'b1;
         end
      endcase
   end

endmodule : scs_frame_decode

// file: verilog/scs_comm_setting.sv
// Communication setting of one serial channel: register, latch and framing helpers.
// Assumes a classic Wishbone master on clk_sys and a shift engine that reports events.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
`include "scs_defines.svh"
module scs_comm_setting
   import scs_pkg::*;
#(
   parameter bit HAS_NINE_BIT = 1'b1,
   parameter bit HAS_TWO_STOP = 1'b1
)
(
   // Clock and reset
   input logic clk_sys,
   input logic rst,
   // Wishbone slave
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [19:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Channel state
   output logic channel_running_flag,
   // Framing controls for the shift engine
   output logic transmit_enable_bit,
   output logic receive_enable_bit,
   output logic data_phase_bit,
   output logic clock_polarity_bit,
   output logic msb_first,
   output logic parity_present,
   output logic [1:0] stop_count,
   output logic [3:0] data_bits,
   output logic [1:0] channel_mode,
   // Events from the shift engine
   input logic [8:0] tx_data,
   input logic [8:0] rx_data,
   input logic rx_parity_in,
   input logic rx_parity_strobe,
   input logic rx_done_event,
   input logic rx_error_event,
   input logic tx_data_done,
   input logic tx_stop_tick,
   // Results back to the shift engine and interrupt controller
   output logic tx_parity_bit,
   output logic rx_parity_error,
   output logic receive_done_irq,
   output logic receive_error_irq,
   output logic transfer_end_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam logic [15:0] SET_WMASK = `SCS_SET_WMASK
      & ~(HAS_TWO_STOP ? 16'h0000 : 16'h0020)
      & ~(HAS_NINE_BIT ? 16'h0000 : 16'h0002);
   localparam logic [15:0] SET_FIXED1 = `SCS_SET_FIXED1
      | (HAS_NINE_BIT ? 16'h0000 : 16'h0002);

   logic [15:0] setting; // Software copy of the setting register
   logic [1:0] mode_field; // Software copy of the mode field
   logic [15:0] active_setting; // Copy seen by the shift engine
   logic [1:0] active_mode; // Mode seen by the shift engine
   logic running; // Channel operation enabled
   logic bus_req; // Bus request present
   logic wr_take; // Write takes effect this edge
   logic wr_setting; // Accepted setting write
   logic start_cmd; // Start command written
   logic stop_cmd; // Stop command written
   logic [31:0] next_rd; // Read data for the current address
   scs_mode_type dec_mode; // Decoded mode
   logic dec_tx_en;
   logic dec_rx_en;
   scs_parity_type dec_parity;
   logic dec_msb;
   logic [1:0] dec_stop;
   logic [3:0] dec_bits;
   logic dec_err_sel;
   logic dec_illegal;
   logic [8:0] len_mask; // Right-aligned data mask
   logic end_pending; // Waiting for stop bits to finish
   logic [1:0] stop_seen; // Stop bits shifted so far

   ////////////////////////////////////////////////////////////////////////
   // Wishbone handshake: ack one cycle after the request, dropped after one
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_take = bus_req & wb_we_i & wb_ack_o;
   // Byte-lane writes are ignored so a half-written setting never exists
   assign wr_setting = wr_take & (wb_adr_i == `SCS_ADR_SETTING)
      & (wb_sel_i[1:0] == 2'b11) & ~running;
   assign start_cmd = wr_take & (wb_adr_i == `SCS_ADR_CTRL) & wb_sel_i[0]
      & wb_dat_i[`SCS_CTRL_START];
   assign stop_cmd = wr_take & (wb_adr_i == `SCS_ADR_CTRL) & wb_sel_i[0]
      & wb_dat_i[`SCS_CTRL_STOP];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   // Read mux; unmapped addresses answer with zero
   always_comb
   begin
      next_rd = 32'h0000_0000;
      unique case (wb_adr_i)
         `SCS_ADR_SETTING: next_rd[15:0] = setting;
         `SCS_ADR_MODE: next_rd[1:0] = mode_field;
         `SCS_ADR_CTRL:
         begin
            next_rd[`SCS_CTRL_START] = running;
            next_rd[`SCS_CTRL_ILLEGAL] = dec_illegal;
         end
         default: next_rd = 32'h0000_0000;
      endcase
   end

   // Read data is captured as the ack is raised
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (bus_req & ~wb_ack_o & ~wb_we_i)
      begin
         wb_dat_o <= next_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Setting and mode registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         setting <= `SCS_SET_RESET;
      end
      else if (wr_setting)
      begin
         // Reserved bits stay zero, bit 2 and absent upper length stay one
         setting <= (wb_dat_i[15:0] & SET_WMASK) | SET_FIXED1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         mode_field <= 2'b00;
      end
      else if (wr_take & (wb_adr_i == `SCS_ADR_MODE) & wb_sel_i[0] & ~running)
      begin
         mode_field <= wb_dat_i[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run control and latch; stop wins when both are written together
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         running <= 1'b0;
      end
      else if (stop_cmd)
      begin
         running <= 1'b0;
      end
      else if (start_cmd)
      begin
         running <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         active_setting <= `SCS_SET_RESET;
         active_mode <= 2'b00;
      end
      else if (start_cmd & ~stop_cmd & ~running)
      begin
         active_setting <= setting;
         active_mode <= mode_field;
      end
   end

   scs_frame_decode #(
      .HAS_NINE_BIT(HAS_NINE_BIT)
   ) u_decode (
      .setting(active_setting),
      .mode_field(active_mode),
      .mode(dec_mode),
      .tx_en(dec_tx_en),
      .rx_en(dec_rx_en),
      .parity(dec_parity),
      .msb_first(dec_msb),
      .stop_count(dec_stop),
      .data_bits(dec_bits),
      .err_sel(dec_err_sel),
      .illegal(dec_illegal)
   );

   // Framing outputs are registered; enables are gated by the run state
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         transmit_enable_bit <= 1'b0;
         receive_enable_bit <= 1'b0;
         data_phase_bit <= 1'b0;
         clock_polarity_bit <= 1'b0;
         msb_first <= 1'b1;
         parity_present <= 1'b0;
         stop_count <= 2'd1;
         data_bits <= `SCS_LEN_EIGHT;
         channel_mode <= 2'b00;
         channel_running_flag <= 1'b0;
      end
      else
      begin
         transmit_enable_bit <= running & dec_tx_en;
         receive_enable_bit <= running & dec_rx_en;
         data_phase_bit <= active_setting[`SCS_DAP_BIT];
         clock_polarity_bit <= active_setting[`SCS_CKP_BIT];
         msb_first <= dec_msb;
         parity_present <= (dec_mode == SCS_ASYNC) & (dec_parity != SCS_PAR_NONE);
         stop_count <= dec_stop;
         data_bits <= dec_bits;
         channel_mode <= active_mode;
         channel_running_flag <= running;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parity generation and checking over the right-aligned data only
   always_comb
   begin
      len_mask = 9'h0FF;
      unique case (dec_bits)
         `SCS_LEN_SEVEN: len_mask = 9'h07F;
         `SCS_LEN_NINE: len_mask = 9'h1FF;
         default: len_mask = 9'h0FF;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_parity_bit <= 1'b0;
      end
      else
      begin
         unique case (dec_parity)
            SCS_PAR_NONE: tx_parity_bit <= 1'b0;
            SCS_PAR_ZERO: tx_parity_bit <= 1'b0;
            SCS_PAR_EVEN: tx_parity_bit <= ^(tx_data & len_mask);
            SCS_PAR_ODD: tx_parity_bit <= ~^(tx_data & len_mask);
         endcase
      end
   end

   // Only even and odd codes are judged; zero parity is received unchecked
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_parity_error <= 1'b0;
      end
      else
      begin
         rx_parity_error <= running & rx_parity_strobe & (dec_mode == SCS_ASYNC)
            & (((dec_parity == SCS_PAR_EVEN) & (^(rx_data & len_mask) != rx_parity_in))
            | ((dec_parity == SCS_PAR_ODD) & (~^(rx_data & len_mask) != rx_parity_in)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive interrupt routing
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         receive_done_irq <= 1'b0;
         receive_error_irq <= 1'b0;
      end
      else
      begin
         // An error with the select set goes only to the error line
         receive_error_irq <= running & rx_error_event & dec_err_sel;
         receive_done_irq <= running
            & ((rx_done_event | rx_error_event) & ~(rx_error_event & dec_err_sel));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer-end interrupt after the last configured stop bit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         end_pending <= 1'b0;
         stop_seen <= 2'd0;
         transfer_end_irq <= 1'b0;
      end
      else
      begin
         transfer_end_irq <= 1'b0;
         if (~running)
         begin
            end_pending <= 1'b0;
            stop_seen <= 2'd0;
         end
         else if (tx_data_done)
         begin
            // No stop bits: the frame ends with its last data bit
            transfer_end_irq <= (dec_stop == 2'd0);
            end_pending <= (dec_stop != 2'd0);
            stop_seen <= 2'd0;
         end
         else if (end_pending & tx_stop_tick)
         begin
            if (stop_seen + 2'd1 == dec_stop)
            begin
               transfer_end_irq <= 1'b1;
               end_pending <= 1'b0;
               stop_seen <= 2'd0;
            end
            else
            begin
               stop_seen <= stop_seen + 2'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_setting_write;
      wr_setting;
   endsequence

   sequence s_error_select;
      running && rx_error_event && dec_err_sel;
   endsequence

   a_reset_value: assert property (@(posedge clk_sys)
      $past(rst) && !rst |-> setting == `SCS_SET_RESET)
      else $error("setting not at reset value after reset");

   a_enable_decode: assert property (@(posedge clk_sys) disable iff (rst)
      running && $past(running) |->
      transmit_enable_bit == active_setting[`SCS_TXE_BIT]
      && receive_enable_bit == active_setting[`SCS_RXE_BIT])
      else $error("enable outputs do not follow enable bits");

   a_error_route: assert property (@(posedge clk_sys) disable iff (rst)
      s_error_select |=> receive_error_irq && !receive_done_irq)
      else $error("selected receive error not routed to error line");

   a_plain_error: assert property (@(posedge clk_sys) disable iff (rst)
      running && rx_error_event && !dec_err_sel |=> receive_done_irq && !receive_error_irq)
      else $error("unselected receive error not routed to done line");

   // Seven-bit frames leave the top data bit out of the parity sum
   a_even_parity: assert property (@(posedge clk_sys) disable iff (rst)
      dec_parity == SCS_PAR_EVEN && $stable(dec_parity) && dec_bits != `SCS_LEN_NINE
      |=> tx_parity_bit
      == ^($past(tx_data[7:0]) & (($past(dec_bits) == `SCS_LEN_SEVEN) ? 8'h7F : 8'hFF)))
      else $error("even parity bit wrong");

   a_bit_order: assert property (@(posedge clk_sys) disable iff (rst)
      running && $past(running) |-> msb_first == !active_setting[`SCS_ORD_BIT])
      else $error("bit order output wrong");

   a_locked_write: assert property (@(posedge clk_sys) disable iff (rst)
      running && wb_ack_o && wb_we_i && wb_adr_i == `SCS_ADR_SETTING |=> $stable(setting))
      else $error("setting changed while running");

   a_full_write: assert property (@(posedge clk_sys) disable iff (rst)
      s_setting_write |-> wb_sel_i[1:0] == 2'b11 ##1 setting[11] == 1'b0 && setting[2])
      else $error("setting written by partial access or reserved bits wrong");

   a_setting_hold: assert property (@(posedge clk_sys) disable iff (rst)
      running && $past(running) |-> $stable(active_setting) && $stable(active_mode))
      else $error("latched setting changed while running");

   a_no_stop_end: assert property (@(posedge clk_sys) disable iff (rst)
      running && tx_data_done && dec_stop == 2'd2 |=> !transfer_end_irq)
      else $error("transfer end raised before stop bits");

endmodule : scs_comm_setting

// file: verification/scs_engine_peer.sv
// Behavioural shift engine facing the setting block: data words and event pulses.
// Assumes the bench calls its tasks from one process, clocked on clk_sys.
`timescale 1ns/1ns
module scs_engine_peer
(
   // Clock
   input wire logic clk_sys,
   // Data toward the setting block
   output logic [8:0] tx_data,
   output logic [8:0] rx_data,
   output logic rx_parity_in,
   // Event pulses, one cycle each
   output logic rx_parity_strobe,
   output logic rx_done_event,
   output logic rx_error_event,
   output logic tx_data_done,
   output logic tx_stop_tick
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle state at time zero
   initial
   begin
      {tx_data, rx_data, rx_parity_in} = '0;
      {tx_stop_tick, tx_data_done, rx_error_event, rx_done_event, rx_parity_strobe} = '0;
   end
   // Load words just after an edge, as a real engine would
   task automatic load(input logic [8:0] t, input logic [8:0] r, input logic p);
      @(posedge clk_sys);
      tx_data <= t;
      rx_data <= r;
      rx_parity_in <= p;
   endtask : load
   // One-cycle pulse on chosen events; ticks follow data done
   task automatic fire(input logic [4:0] ev);
      @(posedge clk_sys);
      {tx_stop_tick, tx_data_done, rx_error_event, rx_done_event, rx_parity_strobe} <= ev;
      @(posedge clk_sys);
      {tx_stop_tick, tx_data_done, rx_error_event, rx_done_event, rx_parity_strobe} <= '0;
   endtask : fire
endmodule : scs_engine_peer

// file: verification/testbench.sv
// Self-checking bench for the channel setting block and its engine model.
// Assumes a one-cycle Wishbone answer and framing outputs one cycle after start.
`timescale 1ns/1ns
`include "scs_defines.svh"
module testbench;
   // Bus and clock
   logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [19:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   // Block outputs and engine lines
   logic channel_running_flag, transmit_enable_bit, receive_enable_bit, data_phase_bit;
   logic clock_polarity_bit, msb_first, parity_present, tx_parity_bit, rx_parity_error;
   logic receive_done_irq, receive_error_irq, transfer_end_irq;
   logic [1:0] stop_count, channel_mode;
   logic [3:0] data_bits;
   logic [8:0] tx_data, rx_data;
   logic rx_parity_in, rx_parity_strobe, rx_done_event, rx_error_event;
   logic tx_data_done, tx_stop_tick;
   // Counters
   int err_count = 0, num_checks = 0, n_done, n_err, n_end, n_par;
   logic [15:0] s;
   int stop_exp[4] = '{0, 1, 2, 1};
   int len_exp[4] = '{8, 9, 7, 8};

   scs_comm_setting dut (
      .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_running_flag(channel_running_flag),
      .transmit_enable_bit(transmit_enable_bit), .receive_enable_bit(receive_enable_bit),
      .data_phase_bit(data_phase_bit), .clock_polarity_bit(clock_polarity_bit),
      .msb_first(msb_first), .parity_present(parity_present), .stop_count(stop_count),
      .data_bits(data_bits), .channel_mode(channel_mode), .tx_data(tx_data),
      .rx_data(rx_data), .rx_parity_in(rx_parity_in), .rx_parity_strobe(rx_parity_strobe),
      .rx_done_event(rx_done_event), .rx_error_event(rx_error_event),
      .tx_data_done(tx_data_done), .tx_stop_tick(tx_stop_tick), .tx_parity_bit(tx_parity_bit),
      .rx_parity_error(rx_parity_error), .receive_done_irq(receive_done_irq),
      .receive_error_irq(receive_error_irq), .transfer_end_irq(transfer_end_irq)
   );
   scs_engine_peer peer (
      .clk_sys(clk_sys), .tx_data(tx_data), .rx_data(rx_data), .rx_parity_in(rx_parity_in),
      .rx_parity_strobe(rx_parity_strobe), .rx_done_event(rx_done_event),
      .rx_error_event(rx_error_event), .tx_data_done(tx_data_done), .tx_stop_tick(tx_stop_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 100 MHz
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Pulse counters, so a pulse is never missed between polls
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         {n_done, n_err, n_end, n_par} <= '0;
      else
      begin
         n_done <= n_done + receive_done_irq;
         n_err <= n_err + receive_error_irq;
         n_end <= n_end + transfer_end_irq;
         n_par <= n_par + rx_parity_error;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // One classic cycle; ack is sampled at the edge, before the slave updates it
   task automatic wb(input logic [19:0] a, input logic we, input logic [3:0] sel,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, sel, d};
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (n >= 20)
      begin
         err_count++;
         $display("unexpected at %0t: no bus answer", $time);
         close_out();
      end
   endtask : wb
   task automatic settle(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 59'd0};
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      wb(`SCS_ADR_SETTING, 1'b0, 4'hF, 0); check(rd, 32'h0000_0087, "reset");
      wb(20'hF_0000, 1'b0, 4'hF, 0); check(rd, 32'h0000_0000, "unmapped");
      wb(`SCS_ADR_SETTING, 1'b1, 4'hF, 32'h0000_FFFF);
      wb(`SCS_ADR_SETTING, 1'b0, 4'hF, 0); check(rd, 32'h0000_F7B7, "mask");
      wb(`SCS_ADR_SETTING, 1'b1, 4'h2, 0);
      wb(`SCS_ADR_SETTING, 1'b0, 4'hF, 0); check(rd, 32'h0000_F7B7, "lane");
      wb(`SCS_ADR_MODE, 1'b1, 4'hF, 32'h0000_0001); // Asynchronous mode
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         s = {i[1:0], i[1:0], 1'b0, i[0], i[1:0], i[0], 1'b0, i[1:0], 2'b01, i[1:0]};
         wb(`SCS_ADR_SETTING, 1'b1, 4'hF, {16'h0000, s});
         wb(`SCS_ADR_CTRL, 1'b1, 4'hF, 32'h0000_0001);
         settle(3);
         check(transmit_enable_bit, i[1], "tx enable");
         check(receive_enable_bit, i[0], "rx enable");
         check({data_phase_bit, clock_polarity_bit}, i[1:0], "phase");
         check(msb_first, !i[0], "order");
         check(parity_present, i != 0, "parity");
         check(stop_count, stop_exp[i], "stop");
         check(data_bits, len_exp[i], "length");
         check(channel_mode, 1, "mode");
         wb(`SCS_ADR_CTRL, 1'b0, 4'hF, 0); check(rd, (i == 1 || i == 2) ? 1 : 3, "ctrl");
         wb(`SCS_ADR_SETTING, 1'b1, 4'hF, 32'h0000_0087);
         wb(`SCS_ADR_SETTING, 1'b0, 4'hF, 0); check(rd, s, "held");
         peer.load(9'h0E1, 9'h0E1, 1'b0);
         settle(2); check(tx_parity_bit, i >= 2, "tx parity");
         peer.fire(5'b00001);
         peer.fire(5'b00100);
         settle(2);
         check(n_par, i >= 2, "rx parity");
         check(n_err, i[0], "error route");
         check(n_done, !i[0], "done route");
         for (int k = 0; k <= stop_exp[i]; k++)
         begin
            peer.fire(k == 0 ? 5'b01000 : 5'b10000);
            settle(2); check(n_end, k == stop_exp[i], "transfer end");
         end
         wb(`SCS_ADR_CTRL, 1'b1, 4'hF, 32'h0000_0002);
         settle(3);
         check({channel_running_flag, transmit_enable_bit}, 0, "stopped");
         rst <= 1'b1;
         settle(1);
         rst <= 1'b0;
         wb(`SCS_ADR_MODE, 1'b1, 4'hF, 32'h0000_0001);
         $display("test framing code %0d done", i);
      end
      // Clocked, two-wire and prohibited modes, with the settings software keeps there
      for (int m = 0; m < 4; m++)
      begin
         if (m != 1)
         begin
            s = (m == 0) ? 16'hC007 : 16'hC017;
            wb(`SCS_ADR_MODE, 1'b1, 4'hF, m);
            wb(`SCS_ADR_SETTING, 1'b1, 4'hF, {16'h0000, s});
            wb(`SCS_ADR_CTRL, 1'b1, 4'hF, 32'h0000_0001);
            settle(3);
            check(channel_running_flag, 1, "running");
            check(channel_mode, m, "other mode");
            check(msb_first, 1, "mode order");
            check(parity_present, 0, "mode parity");
            check(stop_count, (m == 0) ? 0 : 1, "mode stop");
            check(data_bits, 8, "mode length");
            wb(`SCS_ADR_CTRL, 1'b0, 4'hF, 0);
            check(rd, (m == 3) ? 3 : 1, "mode ctrl");
            peer.fire(5'b00100);
            settle(2);
            check(n_err, 0, "no error line");
            check(n_done, (m == 0) ? 1 : m, "mode done line");
            wb(`SCS_ADR_CTRL, 1'b1, 4'hF, 32'h0000_0002);
            $display("test mode %0d done", m);
         end
      end
      close_out();
   end
   // Overall limit on run length
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      $display("unexpected at %0t: run limit reached", $time);
      close_out();
   end
endmodule : testbench
